// file: core/rsdp_pkg.sv
// Operation
// - Asynchronous mode turns off packet handling and buffering; raw bits pass straight through.
// - Asynchronous mode forces whitening, interleaving, FEC, Manchester and MSK off.
// - Asynchronous transmit input is sampled at eight times the data rate.
// - Asynchronous receive outputs raw undecided data; host oversamples, tolerates 1/8 jitter.
// - Asynchronous receive output may carry rare one-clock glitches; host filters them.
// - Synchronous serial mode is chosen by the packet format field.
// - Synchronous mode: device drives bit clock for host transmit launch and receive sampling.
// - Transmit data enters on pin zero, forced to input while transmitting.
// - Synchronous transmit bits reach the modulator eight bit periods late.
// - Receive data may be routed to any general pin by its select field.
// - Received data appears on the output nine bit periods after reception starts.
// - Synchronous mode inserts preamble and sync, and detects the sync word, per sync word mode.
// - With sync handling on, device adds/strips preamble and sync; features except address filtering stay available.
// - Address filtering is unavailable whenever synchronous serial mode is active.
// - Hard decision output is two bits; only upper bit matters for two-level formats.
// - Symbol tick is high for half a symbol period per new symbol.
// - Symbol tick and hard data are selectable on pins in both serial modes.
package rsdp_pkg;
   localparam int unsigned AW          = 8;
   localparam int unsigned DW          = 32;
   localparam logic [7:0]  REG_CFG     = 8'h00;
   localparam logic [7:0]  REG_FEAT    = 8'h04;
   localparam logic [7:0]  REG_PIN0    = 8'h08;
   localparam logic [7:0]  REG_PIN1    = 8'h0c;
   localparam logic [7:0]  REG_PIN2    = 8'h10;
   localparam logic [7:0]  REG_RATE    = 8'h14;
   localparam logic [7:0]  REG_STAT    = 8'h18;
   // configuration word layout
   localparam int unsigned CFG_FMT_LO  = 0;
   localparam int unsigned CFG_SYNC_LO = 2;
   localparam int unsigned CFG_FOUR    = 5;
   localparam int unsigned SYNCM_W     = 3;
   // feature bits
   localparam int unsigned FEAT_W      = 6;
   localparam int unsigned F_WHITEN    = 0;
   localparam int unsigned F_INTERLV   = 1;
   localparam int unsigned F_FEC       = 2;
   localparam int unsigned F_MANCH     = 3;
   localparam int unsigned F_MSK       = 4;
   localparam int unsigned F_ADDR      = 5;
   // status word layout above the effective features
   localparam int unsigned S_PKT       = 6;
   localparam int unsigned S_TX        = 7;
   localparam int unsigned S_FOUND     = 8;
   localparam int unsigned S_PIN0      = 9;
   localparam int unsigned SEL_W       = 6;
   localparam int unsigned RATE_W      = 16;
   typedef enum logic [1:0] {
      RSDP_FMT_FIFO  = 2'h0,
      RSDP_FMT_SYNC  = 2'h1,
      RSDP_FMT_RSVD  = 2'h2,
      RSDP_FMT_ASYNC = 2'h3
   } rsdp_fmt_t;
   // pin signal selection codes
   localparam logic [5:0]  SEL_SER_CLK = 6'h0b;
   localparam logic [5:0]  SEL_SYNC_DO = 6'h0c;
   localparam logic [5:0]  SEL_ASYN_DO = 6'h0d;
   localparam logic [5:0]  SEL_HARD1   = 6'h16;
   localparam logic [5:0]  SEL_HARD0   = 6'h17;
   localparam logic [5:0]  SEL_TICK    = 6'h18;
   localparam logic [5:0]  SEL_HIZ     = 6'h2e;
   localparam logic [5:0]  SEL_LOW     = 6'h2f;
   localparam logic [5:0]  SEL_CLK_LO  = 6'h30;
   localparam logic [5:0]  RST_PIN0    = 6'h3f;
   localparam logic [5:0]  RST_PIN12   = 6'h2e;
   localparam logic [15:0] RST_RATE    = 16'h0001;
   localparam int unsigned TAP_W       = 16;
   // bit timing
   localparam int unsigned OVERSAMPLE  = 8;
   localparam logic [2:0]  PH_HALF     = 3'h3;
   localparam logic [2:0]  PH_LAST     = 3'h7;
   localparam int unsigned TX_LAT      = 8;
   localparam int unsigned RX_LAT      = 9;
   localparam logic [3:0]  RX_LAT_CNT  = 4'h9;
   localparam logic [2:0]  TICK_HALF   = 3'h4;
   // framing inserted by the device
   localparam int unsigned PRE_BITS    = 32;
   localparam int unsigned SYNC_BITS   = 16;
   localparam int unsigned HDR_BITS    = PRE_BITS + SYNC_BITS;
   localparam logic [5:0]  HDR_CNT     = 6'h30;
   localparam logic [31:0] PRE_PAT     = 32'haaaaaaaa;
   localparam logic [15:0] SYNC_WORD   = 16'h5a3c;
endpackage : rsdp_pkg

// file: core/rsdp_rate_gen.sv
`timescale 1ns/1ns
module rsdp_rate_gen
   import rsdp_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [RATE_W-1:0] tick_div,
   output logic                   sample_tick,
   output logic                   bit_tick,
   output logic                   half_tick,
   output logic                   ser_clk
);
   logic [RATE_W-1:0] cnt;
   logic [2:0]        phase;
   wire               wrap     = (cnt >= tick_div);
   wire [RATE_W-1:0]  next_cnt = wrap ? '0 : cnt + 1'b1;

   // one oversample tick per tick_div+1 clocks, eight per bit
   assign sample_tick = wrap;
   assign bit_tick    = wrap && (phase == PH_LAST);
   assign half_tick   = wrap && (phase == PH_HALF);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt   <= '0;
         phase <= '0;
      end
      else
      begin
         cnt   <= next_cnt;
         phase <= wrap ? phase + 3'h1 : phase;
      end
   end

   // clock high in the first half of each bit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ser_clk <= 1'b0;
      else if (bit_tick)
         ser_clk <= 1'b1;
      else if (half_tick)
         ser_clk <= 1'b0;
   end
endmodule : rsdp_rate_gen

// file: core/rsdp_pin_sel.sv
`timescale 1ns/1ns
module rsdp_pin_sel
   import rsdp_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [SEL_W-1:0] sel_code,
   input  wire logic             force_input,
   input  wire logic             clk_grant,
   input  wire logic             ser_clk,
   input  wire logic             sync_data,
   input  wire logic             async_data,
   input  wire logic [1:0]       hard_data,
   input  wire logic             sym_tick,
   input  wire logic [TAP_W-1:0] clk_taps,
   output logic                  pin_out,
   output logic                  pin_oe_n
);
   wire is_clk   = (sel_code >= SEL_CLK_LO);
   wire [3:0] tap_idx = sel_code[3:0];
   wire next_out =
      (sel_code == SEL_SER_CLK) ? ser_clk :
      (sel_code == SEL_SYNC_DO) ? sync_data :
      (sel_code == SEL_ASYN_DO) ? async_data :
      (sel_code == SEL_HARD1)   ? hard_data[1] :
      (sel_code == SEL_HARD0)   ? hard_data[0] :
      (sel_code == SEL_TICK)    ? sym_tick :
      (is_clk && clk_grant)     ? clk_taps[tap_idx] : 1'b0;
   wire next_oe_n = force_input || (sel_code == SEL_HIZ) || (is_clk && !clk_grant);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_out  <= 1'b0;
         pin_oe_n <= 1'b1;
      end
      else
      begin
         pin_out  <= next_out;
         pin_oe_n <= next_oe_n;
      end
   end
endmodule : rsdp_pin_sel

// file: core/rsdp_serial_port.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module rsdp_serial_port
   import rsdp_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic [AW-1:0] reg_addr,
   input  wire logic [DW-1:0] reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [DW-1:0]      reg_rdata,
   input  wire logic          tx_active,
   input  wire logic          rx_active,
   input  wire logic          rx_raw,
   input  wire logic [1:0]    rx_sym,
   input  wire logic          rx_sym_valid,
   output logic               mod_data,
   output logic               pkt_handler_en,
   output logic [FEAT_W-1:0]  feat_eff,
   input  wire logic          general_pin_zero_in,
   output logic               general_pin_zero_out,
   output logic               general_pin_zero_oe_n,
   input  wire logic          general_pin_one_in,
   output logic               general_pin_one_out,
   output logic               general_pin_one_oe_n,
   input  wire logic          general_pin_two_in,
   output logic               general_pin_two_out,
   output logic               general_pin_two_oe_n
);
   // reset release
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // registers
   rsdp_fmt_t          packet_format_select;
   logic [SYNCM_W-1:0] sync_word_mode;
   logic               four_level;
   logic [FEAT_W-1:0]  feat_req;
   logic [SEL_W-1:0]   pin0_signal_select;
   logic [SEL_W-1:0]   pin1_signal_select;
   logic [SEL_W-1:0]   pin2_signal_select;
   logic [RATE_W-1:0]  tick_div;

   wire wr_cfg  = reg_wr && (reg_addr == REG_CFG);
   wire wr_feat = reg_wr && (reg_addr == REG_FEAT);
   wire wr_pin0 = reg_wr && (reg_addr == REG_PIN0);
   wire wr_pin1 = reg_wr && (reg_addr == REG_PIN1);
   wire wr_pin2 = reg_wr && (reg_addr == REG_PIN2);
   wire wr_rate = reg_wr && (reg_addr == REG_RATE);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         packet_format_select <= RSDP_FMT_FIFO;
         sync_word_mode       <= '0;
         four_level           <= 1'b0;
      end
      else if (wr_cfg)
      begin
         packet_format_select <= rsdp_fmt_t'(reg_wdata[CFG_FMT_LO +: 2]);
         sync_word_mode       <= reg_wdata[CFG_SYNC_LO +: SYNCM_W];
         four_level           <= reg_wdata[CFG_FOUR];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         feat_req           <= '0;
         pin0_signal_select <= RST_PIN0;
         pin1_signal_select <= RST_PIN12;
         pin2_signal_select <= RST_PIN12;
         tick_div           <= RST_RATE;
      end
      else
      begin
         feat_req           <= wr_feat ? reg_wdata[FEAT_W-1:0] : feat_req;
         pin0_signal_select <= wr_pin0 ? reg_wdata[SEL_W-1:0] : pin0_signal_select;
         pin1_signal_select <= wr_pin1 ? reg_wdata[SEL_W-1:0] : pin1_signal_select;
         pin2_signal_select <= wr_pin2 ? reg_wdata[SEL_W-1:0] : pin2_signal_select;
         tick_div           <= wr_rate ? reg_wdata[RATE_W-1:0] : tick_div;
      end
   end

   // mode decode
   wire mode_async = (packet_format_select == RSDP_FMT_ASYNC);
   wire mode_sync  = (packet_format_select == RSDP_FMT_SYNC);
   wire sync_hdl   = mode_sync && (sync_word_mode != '0);

   // the mask keeps address filtering off in synchronous mode; asynchronous mode clears every feature
   wire [FEAT_W-1:0] addr_mask  = {{1'b1}, {(FEAT_W-1){1'b0}}};
   wire [FEAT_W-1:0] next_feat  =
      mode_async ? '0 :
      mode_sync  ? (feat_req & ~addr_mask) : feat_req;
   wire next_pkt_en = !mode_async;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         feat_eff       <= '0;
         pkt_handler_en <= 1'b1;
      end
      else
      begin
         feat_eff       <= next_feat;
         pkt_handler_en <= next_pkt_en;
      end
   end

   // pin zero synchroniser; first stage feeds only the second
   logic pin0_meta;
   logic pin0_sync;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin0_meta <= 1'b0;
         pin0_sync <= 1'b0;
      end
      else
      begin
         pin0_meta <= general_pin_zero_in;
         pin0_sync <= pin0_meta;
      end
   end

   // bit timing
   logic sample_tick;
   logic bit_tick;
   logic half_tick;
   logic ser_clk;
   rsdp_rate_gen u_rate (
      .clk         (clk),
      .rst_n       (rst_n),
      .tick_div    (tick_div),
      .sample_tick (sample_tick),
      .bit_tick    (bit_tick),
      .half_tick   (half_tick),
      .ser_clk     (ser_clk)
   );

   // transmit framing: preamble and sync word ahead of the host's payload
   logic [5:0]        hdr_cnt;
   logic              tx_prev;
   logic [TX_LAT-1:0] tx_dly;
   wire hdr_active = (hdr_cnt != '0);
   wire tx_start   = tx_active && !tx_prev;
   wire [HDR_BITS-1:0] hdr_bits = {PRE_PAT, SYNC_WORD};
   wire hdr_bit    = hdr_bits[6'(hdr_cnt - 6'h1)];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hdr_cnt <= '0;
         tx_prev <= 1'b0;
      end
      else
      begin
         tx_prev <= tx_active;
         if (tx_start && sync_hdl)
            hdr_cnt <= HDR_CNT;
         else if (!tx_active)
            hdr_cnt <= '0;
         else if (bit_tick && hdr_active)
            hdr_cnt <= hdr_cnt - 6'h1;
      end
   end

   // host launches on the falling edge, so pin0 is settled at the rising edge;
   // the pin register and the two-flop synchroniser put that level in pin0_sync
   // three clocks after the internal rise, so the shift waits for it
   logic [2:0] rise_dly;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rise_dly <= '0;
      else
         rise_dly <= {rise_dly[1:0], bit_tick};
   end
   wire tx_shift = rise_dly[2] && mode_sync && tx_active && !hdr_active;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_dly <= '0;
      else if (tx_shift)
         tx_dly <= {tx_dly[TX_LAT-2:0], pin0_sync};
   end

   wire next_mod =
      mode_async ? (sample_tick ? pin0_sync : mod_data) :
      !mode_sync ? 1'b0 :
      hdr_active ? (bit_tick ? hdr_bit : mod_data) :
      tx_shift   ? tx_dly[TX_LAT-1] : mod_data;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mod_data <= 1'b0;
      else
         mod_data <= tx_active ? next_mod : 1'b0;
   end

   // receive: raw level straight out, one-clock glitches included
   logic async_dout;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         async_dout <= 1'b0;
      else
         async_dout <= mode_async ? rx_raw : 1'b0;
   end

   // synchronous receive: bit sampled on the bit tick at the end of each bit, sync search, nine-bit line
   logic [SYNC_BITS-1:0] rx_shift;
   logic [RX_LAT-1:0]    rx_dly;
   logic                 sync_found;
   logic [3:0]           rx_cnt;
   logic                 sync_dout;
   wire rx_bit_tick = bit_tick && mode_sync && rx_active;
   wire rx_open     = !sync_hdl || sync_found;
   wire rx_ready    = (rx_cnt == RX_LAT_CNT);
   wire next_found  = sync_found ||
                      ({rx_shift[SYNC_BITS-2:0], rx_raw} == SYNC_WORD);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_shift   <= '0;
         rx_dly     <= '0;
         sync_found <= 1'b0;
         rx_cnt     <= '0;
      end
      else if (!rx_active || !mode_sync)
      begin
         sync_found <= 1'b0;
         rx_cnt     <= '0;
      end
      else if (rx_bit_tick)
      begin
         rx_shift   <= {rx_shift[SYNC_BITS-2:0], rx_raw};
         rx_dly     <= {rx_dly[RX_LAT-2:0], rx_raw};
         sync_found <= sync_hdl && next_found;
         rx_cnt     <= (rx_open && !rx_ready) ? rx_cnt + 4'h1 : rx_cnt;
      end
   end

   // receive bit changes on the falling edge, host samples on the rising one
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sync_dout <= 1'b0;
      else if (!rx_ready)
         sync_dout <= 1'b0;
      else if (half_tick)
         sync_dout <= rx_dly[RX_LAT-1];
   end

   // bit clock is held low while the device sends its own framing
   wire clk_gate = (tx_active && hdr_active) || (rx_active && !rx_open);
   wire ser_clk_out = (mode_sync && !clk_gate) ? ser_clk : 1'b0;

   // symbol tick and hard decision
   logic [1:0] hard_data;
   logic       sym_tick;
   logic [2:0] tick_cnt;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         hard_data <= '0;
      else if (rx_sym_valid)
         hard_data <= four_level ? rx_sym : {rx_sym[1], 1'b0};
   end

   // half a symbol is four oversample ticks
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_cnt <= '0;
      else if (rx_sym_valid)
         tick_cnt <= TICK_HALF;
      else if (sample_tick && tick_cnt != '0)
         tick_cnt <= tick_cnt - 3'h1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sym_tick <= 1'b0;
      else
         sym_tick <= rx_sym_valid || (tick_cnt != '0 && !(sample_tick && tick_cnt == 3'h1));
   end

   // divided clock taps; only one pin may carry one, lowest pin wins
   logic [TAP_W-1:0] clk_taps;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         clk_taps <= '0;
      else
         clk_taps <= clk_taps + 1'b1;
   end
   wire clk0  = (pin0_signal_select >= SEL_CLK_LO);
   wire clk1  = (pin1_signal_select >= SEL_CLK_LO);
   wire clk2  = (pin2_signal_select >= SEL_CLK_LO);
   wire [2:0] grant = {clk2 && !clk0 && !clk1, clk1 && !clk0, clk0};
   wire [2:0] force_in = {1'b0, 1'b0, tx_active};

   // pin routing; receive output may sit on any of the three
   logic [SEL_W-1:0] pin_sel_arr [3];
   logic [2:0]       pin_out;
   logic [2:0]       pin_oe_n;
   assign pin_sel_arr[0] = pin0_signal_select;
   assign pin_sel_arr[1] = pin1_signal_select;
   assign pin_sel_arr[2] = pin2_signal_select;

   for (genvar i = 0; i < 3; i++)
   begin : g_pin
      rsdp_pin_sel u_sel (
         .clk         (clk),
         .rst_n       (rst_n),
         .sel_code    (pin_sel_arr[i]),
         .force_input (force_in[i]),
         .clk_grant   (grant[i]),
         .ser_clk     (ser_clk_out),
         .sync_data   (sync_dout),
         .async_data  (async_dout),
         .hard_data   (hard_data),
         .sym_tick    (sym_tick),
         .clk_taps    (clk_taps),
         .pin_out     (pin_out[i]),
         .pin_oe_n    (pin_oe_n[i])
      );
   end

   assign general_pin_zero_out  = pin_out[0];
   assign general_pin_zero_oe_n = pin_oe_n[0];
   assign general_pin_one_out   = pin_out[1];
   assign general_pin_one_oe_n  = pin_oe_n[1];
   assign general_pin_two_out   = pin_out[2];
   assign general_pin_two_oe_n  = pin_oe_n[2];

   // register read, data one cycle after the strobe
   wire [DW-1:0] stat_word = DW'({pin0_sync, sync_found, tx_active, pkt_handler_en, feat_eff});
   wire [DW-1:0] next_rdata =
      (reg_addr == REG_CFG)  ? DW'({four_level, sync_word_mode, packet_format_select}) :
      (reg_addr == REG_FEAT) ? DW'(feat_req) :
      (reg_addr == REG_PIN0) ? DW'(pin0_signal_select) :
      (reg_addr == REG_PIN1) ? DW'(pin1_signal_select) :
      (reg_addr == REG_PIN2) ? DW'(pin2_signal_select) :
      (reg_addr == REG_RATE) ? DW'(tick_div) :
      (reg_addr == REG_STAT) ? stat_word : '0;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= '0;
      else
         reg_rdata <= reg_rd ? next_rdata : '0;
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_ASYNC_NO_PKT: assert property (mode_async |=> !pkt_handler_en)
      else $error("packet handling left on in asynchronous mode");
   AST_ASYNC_NO_CODING: assert property (mode_async |=> feat_eff == '0)
      else $error("coding feature active in asynchronous mode");
   AST_ASYNC_SAMPLE: assert property (mode_async && tx_active && sample_tick
      |=> mod_data == $past(pin0_sync))
      else $error("transmit level not taken at the oversample tick");
   AST_ASYNC_RAW: assert property (mode_async |=> async_dout == $past(rx_raw))
      else $error("raw receive level not passed through");
   AST_TX_DELAY: assert property (tx_shift && tx_active |=> mod_data == $past(tx_dly[TX_LAT-1]))
      else $error("transmit bit did not leave the eight-bit line");
   AST_PIN0_INPUT: assert property (tx_active ##1 tx_active |=> general_pin_zero_oe_n)
      else $error("pin zero driven while transmitting");
   AST_NO_ADDR_FILT: assert property (mode_sync |=> !feat_eff[F_ADDR])
      else $error("address filtering active in synchronous mode");
   AST_HARD_TWO_LEVEL: assert property (!four_level && rx_sym_valid |=> !hard_data[0])
      else $error("lower decision bit set in two-level format");
   AST_RX_LATENCY: assert property (!rx_ready |=> !sync_dout)
      else $error("receive output before nine bit periods");
   AST_HDR_ONLY_SYNC: assert property (hdr_active |-> sync_hdl)
      else $error("framing inserted without sync handling");
   AST_TICK_START: assert property (rx_sym_valid |=> sym_tick)
      else $error("symbol tick missing after new symbol");

   COV_ASYNC_TX: cover property (mode_async && tx_active && sample_tick);
   COV_SYNC_RX_OUT: cover property (mode_sync && $rose(rx_ready));
   COV_SYNC_FOUND: cover property (sync_hdl && $rose(sync_found));
   COV_HDR_DONE: cover property ($fell(hdr_active) && tx_active);
endmodule : rsdp_serial_port

// file: tb/rsdp_host_model.sv
`timescale 1ns/1ns
module rsdp_host_model
(
   input  wire logic  clk,
   input  wire logic  bit_clk,
   output logic       pin0_drive,
   output logic [63:0] hist,
   output logic [7:0] rises
);
   localparam logic [31:0] TX_PAT = 32'hc5a396e1;
   logic       clk_q;
   logic [4:0] idx;
   initial
   begin
      clk_q = 1'b0;
      idx = 5'h0;
      pin0_drive = 1'b1;
      hist = 64'h0;
      rises = 8'h0;
   end
   // launch only after the falling edge so data is settled at the rise
   always @(posedge clk)
   begin
      clk_q <= bit_clk;
      if (clk_q && !bit_clk)
      begin
         pin0_drive <= TX_PAT[idx];
         idx <= idx + 5'h1;
      end
      if (!clk_q && bit_clk)
      begin
         hist <= {hist[62:0], pin0_drive};
         rises <= (rises == 8'hff) ? rises : rises + 8'h1;
      end
   end
endmodule : rsdp_host_model

// file: tb/rsdp_serial_port_tb_top.sv
`timescale 1ns/1ns
module rsdp_serial_port_tb_top
   import rsdp_pkg::*;
;
   logic          clk, nrst, reg_wr, reg_rd, tx_active, rx_raw, rx_sym_valid, rx_active;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] reg_wdata, reg_rdata;
   logic [1:0]    rx_sym;
   logic          mod_data, pkt_handler_en, host_drive, pin0_lvl, prev;
   logic          p0_out, p0_oe_n, p1_out, p1_oe_n, p2_out, p2_oe_n;
   logic [FEAT_W-1:0] feat_eff;
   logic [63:0]   hist;
   logic [7:0]    rises;
   int            miscompares, check_count;
   assign pin0_lvl = p0_oe_n ? host_drive : p0_out;
   rsdp_serial_port i_rsdp_serial_port (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_active(tx_active), .rx_active(rx_active), .rx_raw(rx_raw), .rx_sym(rx_sym),
      .rx_sym_valid(rx_sym_valid), .mod_data(mod_data), .pkt_handler_en(pkt_handler_en),
      .feat_eff(feat_eff), .general_pin_zero_in(pin0_lvl), .general_pin_zero_out(p0_out),
      .general_pin_zero_oe_n(p0_oe_n), .general_pin_one_in(p1_out),
      .general_pin_one_out(p1_out), .general_pin_one_oe_n(p1_oe_n),
      .general_pin_two_in(p2_out), .general_pin_two_out(p2_out),
      .general_pin_two_oe_n(p2_oe_n));
   rsdp_host_model i_rsdp_host_model (.clk(clk), .bit_clk(p2_out), .pin0_drive(host_drive),
      .hist(hist), .rises(rises));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp, "register read");
   endtask : rd_chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      nrst = 1'b0;
      {reg_wr, reg_rd, tx_active, rx_raw, rx_sym_valid, rx_active} = 6'h0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      rx_sym = 2'h0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(REG_PIN0, {26'h0, RST_PIN0});
      rd_chk(REG_PIN2, {26'h0, RST_PIN12});
      rd_chk(REG_RATE, {16'h0, RST_RATE});
      rd_chk(8'h40, 32'h0);
      // one oversample tick per clock gives the 400 ns bit period
      wr(REG_RATE, 32'h0);
      wr(REG_FEAT, 32'h3f);
      rd_chk(REG_FEAT, 32'h3f);
      #1 chk({26'h0, feat_eff}, 32'h3f, "fifo features");
      $display("done: registers");
      wr(REG_CFG, {30'h0, RSDP_FMT_ASYNC});
      wr(REG_PIN1, {26'h0, SEL_ASYN_DO});
      repeat (2) @(posedge clk);
      #1 chk({26'h0, feat_eff}, 32'h0, "async features");
      chk({31'h0, pkt_handler_en}, 32'h0, "async packet handler");
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         rx_raw <= i[0];
         repeat (4) @(posedge clk);
         #1 chk({30'h0, p1_oe_n, p1_out}, {31'h0, i[0]}, "async rx pin");
      end
      tx_active <= 1'b1;
      repeat (8) @(posedge clk);
      #1 chk({30'h0, p0_oe_n, mod_data}, 32'h3, "async tx level");
      tx_active <= 1'b0;
      $display("done: async");
      wr(REG_CFG, {30'h0, RSDP_FMT_SYNC});
      wr(REG_PIN2, {26'h0, SEL_SER_CLK});
      repeat (2) @(posedge clk);
      #1 chk({26'h0, feat_eff}, 32'h1f, "sync features");
      wr(REG_FEAT, 32'h0);
      tx_active <= 1'b1;
      prev = 1'b0;
      for (int i = 0; i < 600; i++)
      begin
         @(posedge clk);
         #1;
         if (prev && !p2_out && rises > 8'd9)
            chk({31'h0, mod_data}, {31'h0, hist[8]}, "sync tx delay");
         prev = p2_out;
      end
      chk({31'h0, rises > 8'd9}, 32'h1, "bit clock runs");
      tx_active <= 1'b0;
      $display("done: sync tx");
      wr(REG_PIN1, {26'h0, SEL_SYNC_DO});
      rx_raw <= 1'b1;
      rx_active <= 1'b1;
      repeat (40) @(posedge clk);
      #1 chk({31'h0, p1_out}, 32'h0, "sync rx before nine bits");
      repeat (48) @(posedge clk);
      #1 chk({31'h0, p1_out}, 32'h1, "sync rx data");
      rx_active <= 1'b0;
      rx_raw <= 1'b0;
      $display("done: sync rx");
      wr(REG_PIN0, {26'h0, SEL_HARD1});
      wr(REG_PIN1, {26'h0, SEL_HARD0});
      wr(REG_PIN2, {26'h0, SEL_TICK});
      for (int i = 1; i < 4; i++)
      begin
         wr(REG_CFG, (i < 3) ? 32'h21 : 32'h1);
         @(posedge clk);
         rx_sym <= i[1:0];
         rx_sym_valid <= 1'b1;
         @(posedge clk);
         rx_sym_valid <= 1'b0;
         repeat (2) @(posedge clk);
         #1 chk({30'h0, p0_out, p1_out}, {30'h0, i[1], i[0] & (i < 3)}, "hard data");
         chk({31'h0, p2_out}, 32'h1, "tick high");
         repeat (12) @(posedge clk);
         #1 chk({31'h0, p2_out}, 32'h0, "tick low");
      end
      $display("done: symbols");
      print_verdict();
   end
endmodule : rsdp_serial_port_tb_top
